// ---- prb_defines.svh ----
`ifndef PRB_DEFINES_SVH
`define PRB_DEFINES_SVH

// ********************************************************************
// Register offsets.
// ********************************************************************
`define PRB_ADDR_MON_CFG    10'h01A
`define PRB_ADDR_PLL_CTRL   10'h01D
`define PRB_ADDR_STATUS     10'h01F
`define PRB_ADDR_INT_STAT   10'h040
`define PRB_ADDR_INT_CLR    10'h041
`define PRB_ADDR_INT_EN     10'h042

// ********************************************************************
// Field positions.
// ********************************************************************
`define PRB_BIT_LOCK        0
`define PRB_BIT_FIRST_REFERENCE_INPUT_HI     1
`define PRB_BIT_SECOND_REFERENCE_INPUT_HI     2
`define PRB_BIT_VCO_HI      3
`define PRB_BIT_SECOND_REFERENCE_INPUT_SEL    4
`define PRB_BIT_HOLD_ACT    5
`define PRB_BIT_CAL_DONE    6
`define PRB_BIT_RB_DIS      4
`define PRB_BIT_THR_SEL     6
`define PRB_BIT_HOLD_EN_LO  0
`define PRB_BIT_HOLD_EN_HI  2

// Interrupt event positions.
`define PRB_EV_LOCK_CHG     0
`define PRB_EV_CAL_DONE     1
`define PRB_EV_HOLD_ENTER   2
`define PRB_EV_REF_SWITCH   3

// ********************************************************************
// Reset values.
// ********************************************************************
`define PRB_RST_BYTE        8'h00
`define PRB_RST_EVENTS      4'h0

`endif

// ---- prb_irq.sv ----
`timescale 1ns/1ps

// ********************************************************************
// Sticky event bits, enable gating and one level interrupt.
// ********************************************************************
module prb_irq #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Events and software control.
  input  wire logic [WIDTH-1:0] event_set,
  input  wire logic [WIDTH-1:0] clear_bits,
  input  wire logic [WIDTH-1:0] enable_bits,
  // Results.
  output logic      [WIDTH-1:0] status,
  output logic                  irq
);

  logic [WIDTH-1:0] status_r;
  logic [WIDTH-1:0] status_nxt;
  logic             irq_r;
  logic             irq_nxt;

  if (WIDTH < 1 || WIDTH > 8)
  begin : g_bad_width
    $error("prb_irq needs WIDTH from one to eight");
  end

  // A set arriving with its clear keeps the bit set.
  always_comb
  begin
    status_nxt = (status_r & ~clear_bits) | event_set;
    irq_nxt    = |(status_nxt & enable_bits);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      status_r <= '0;
      irq_r    <= 1'b0;
    end
    else
    begin
      status_r <= status_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign status = status_r;
  assign irq    = irq_r;

endmodule : prb_irq

// ---- prb_pkg.sv ----
package prb_pkg;

  typedef logic [7:0] prb_byte_t;
  typedef logic [3:0] prb_events_t;

endpackage : prb_pkg

// ---- prb_status.sv ----
// What this block does
// - Bit 6 reads one once oscillator calibration has completed, else zero.
// - Bit 5 reads one while the PLL is really in holdover.
// - Holdover bit follows the holdover state, never the holdover enable setting.
// - Bit 4 reads zero for first reference, one for second reference.
// - Bit 3 reads one when oscillator frequency is above its threshold.
// - Bit 2 reads one when second reference exceeds threshold chosen by 0x01A bit 6.
// - Bit 1 reads one when first reference exceeds its threshold frequency.
// - Bit 0 reads one when the digital lock detector reports lock.
// - All status bits are read only and show live internal state.
// - Readback disable set to one suppresses status readback; zero enables it.
`timescale 1ns/1ps
`include "prb_defines.svh"

module prb_status #(
  parameter int ADDR_W = 10
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [7:0]        rd_data,
  // Live PLL state, asynchronous to clock.
  input  wire logic              vco_cal_done,
  input  wire logic              holdover_state,
  input  wire logic              second_reference_input_sel,
  input  wire logic              vco_freq_high,
  input  wire logic              second_reference_input_high,
  input  wire logic              first_reference_input_high,
  input  wire logic              lock_detect,
  // Configuration to the PLL circuits.
  output logic      [7:0]        pll_ctrl,
  output logic      [7:0]        mon_cfg,
  // Interrupt.
  output logic                   irq
);

  // ******************************************************************
  // Parameter check.
  // ******************************************************************
  if (ADDR_W < 7)
  begin : g_bad_addr
    $error("prb_status needs ADDR_W of at least seven");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] offs);
    hit = (a == ADDR_W'(offs));
  endfunction : hit

  // ******************************************************************
  // Synchronised PLL state.
  // ******************************************************************
  logic [6:0] live_s;

  prb_sync #(
    .WIDTH (7)
  ) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({vco_cal_done, holdover_state, second_reference_input_sel,
                vco_freq_high, second_reference_input_high,
                first_reference_input_high, lock_detect}),
    .sync_out (live_s)
  );

  // Bit 7 is reserved and reads zero.
  prb_pkg::prb_byte_t status_v;
  assign status_v = {1'b0, live_s};

  // ******************************************************************
  // Configuration registers and event edges.
  // ******************************************************************
  prb_pkg::prb_byte_t   ctrl_r;
  prb_pkg::prb_byte_t   ctrl_nxt;
  prb_pkg::prb_byte_t   thr_r;
  prb_pkg::prb_byte_t   thr_nxt;
  prb_pkg::prb_events_t en_r;
  prb_pkg::prb_events_t en_nxt;
  prb_pkg::prb_byte_t   prev_r;
  prb_pkg::prb_byte_t   prev_nxt;
  prb_pkg::prb_events_t clr_v;
  prb_pkg::prb_events_t ev_v;
  prb_pkg::prb_events_t int_st;

  // The status offset is absent here, so writes to it fall away.
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    thr_nxt  = thr_r;
    en_nxt   = en_r;
    clr_v    = `PRB_RST_EVENTS;
    prev_nxt = status_v;
    if (wr_en)
    begin
      if (hit(addr, `PRB_ADDR_PLL_CTRL))
      begin
        ctrl_nxt = wr_data;
      end
      if (hit(addr, `PRB_ADDR_MON_CFG))
      begin
        thr_nxt = wr_data;
      end
      if (hit(addr, `PRB_ADDR_INT_EN))
      begin
        en_nxt = wr_data[3:0];
      end
      if (hit(addr, `PRB_ADDR_INT_CLR))
      begin
        clr_v = wr_data[3:0];
      end
    end
  end

  // Events come from edges of the synchronised state.
  always_comb
  begin
    ev_v = `PRB_RST_EVENTS;
    ev_v[`PRB_EV_LOCK_CHG]   = status_v[`PRB_BIT_LOCK] ^ prev_r[`PRB_BIT_LOCK];
    ev_v[`PRB_EV_CAL_DONE]   = status_v[`PRB_BIT_CAL_DONE] & ~prev_r[`PRB_BIT_CAL_DONE];
    ev_v[`PRB_EV_HOLD_ENTER] = status_v[`PRB_BIT_HOLD_ACT] & ~prev_r[`PRB_BIT_HOLD_ACT];
    ev_v[`PRB_EV_REF_SWITCH] = status_v[`PRB_BIT_SECOND_REFERENCE_INPUT_SEL] ^ prev_r[`PRB_BIT_SECOND_REFERENCE_INPUT_SEL];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `PRB_RST_BYTE;
      thr_r  <= `PRB_RST_BYTE;
      en_r   <= `PRB_RST_EVENTS;
      prev_r <= `PRB_RST_BYTE;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      thr_r  <= thr_nxt;
      en_r   <= en_nxt;
      prev_r <= prev_nxt;
    end
  end

  prb_irq #(
    .WIDTH (4)
  ) u_irq (
    .clock       (clock),
    .rst_b       (rst_b),
    .event_set   (ev_v),
    .clear_bits  (clr_v),
    .enable_bits (en_r),
    .status      (int_st),
    .irq         (irq)
  );

  // ******************************************************************
  // Read path.
  // ******************************************************************
  prb_pkg::prb_byte_t rd_r;
  prb_pkg::prb_byte_t rd_nxt;

  // Data stand only in the cycle after the read strobe.
  always_comb
  begin
    rd_nxt = `PRB_RST_BYTE;
    if (rd_en)
    begin
      if (hit(addr, `PRB_ADDR_STATUS))
      begin
        rd_nxt = ctrl_r[`PRB_BIT_RB_DIS] ? `PRB_RST_BYTE : status_v;
      end
      else if (hit(addr, `PRB_ADDR_PLL_CTRL))
      begin
        rd_nxt = ctrl_r;
      end
      else if (hit(addr, `PRB_ADDR_MON_CFG))
      begin
        rd_nxt = thr_r;
      end
      else if (hit(addr, `PRB_ADDR_INT_STAT))
      begin
        rd_nxt = {4'h0, int_st};
      end
      else if (hit(addr, `PRB_ADDR_INT_EN))
      begin
        rd_nxt = {4'h0, en_r};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rd_r <= `PRB_RST_BYTE;
    end
    else
    begin
      rd_r <= rd_nxt;
    end
  end

  assign rd_data  = rd_r;
  assign pll_ctrl = ctrl_r;
  assign mon_cfg  = thr_r;

  // ******************************************************************
  // Assertions.
  // ******************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  logic st_rd;
  assign st_rd = rd_en && hit(addr, `PRB_ADDR_STATUS) && !ctrl_r[`PRB_BIT_RB_DIS];

  a_cal_done_bit: assert property (st_rd |=> rd_data[6] == $past(vco_cal_done, 3))
    else $error("calibration bit does not follow calibration done");
  a_hold_bit: assert property (st_rd |=> rd_data[5] == $past(holdover_state, 3))
    else $error("holdover bit does not follow holdover state");
  a_hold_not_en: assert property (st_rd && ctrl_r[`PRB_BIT_HOLD_EN_HI]
      && ctrl_r[`PRB_BIT_HOLD_EN_LO] && !$past(holdover_state, 2) |=> !rd_data[5])
    else $error("holdover bit mirrors the holdover enable");
  a_ref_sel_bit: assert property (status_v[4] == $past(second_reference_input_sel, 2))
    else $error("reference select bit is wrong");
  a_vco_hi_bit: assert property (status_v[3] == $past(vco_freq_high, 2))
    else $error("oscillator monitor bit is wrong");
  a_second_reference_input_hi_bit: assert property (status_v[2] == $past(second_reference_input_high, 2))
    else $error("second reference monitor bit is wrong");
  a_first_reference_input_hi_bit: assert property (status_v[1] == $past(first_reference_input_high, 2))
    else $error("first reference monitor bit is wrong");
  a_lock_bit: assert property (st_rd |=> rd_data[0] == $past(lock_detect, 3))
    else $error("lock bit does not follow lock detect");
  a_status_live: assert property (st_rd |=> rd_data == $past(status_v) && !rd_data[7])
    else $error("status read does not show live state");
  a_rb_disabled: assert property (rd_en && hit(addr, `PRB_ADDR_STATUS)
      && ctrl_r[`PRB_BIT_RB_DIS] |=> rd_data == 8'h00)
    else $error("status read while readback disabled");
  a_wr_ignored: assert property (wr_en && hit(addr, `PRB_ADDR_STATUS)
      |=> $stable(ctrl_r) && $stable(thr_r) && $stable(en_r))
    else $error("status write changed state");
  a_rd_one_cycle: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data outside the read cycle");

  // ******************************************************************
  // Register and interrupt checks.
  // ******************************************************************
  a_ctrl_write: assert property (wr_en && hit(addr, `PRB_ADDR_PLL_CTRL)
      |=> pll_ctrl == $past(wr_data))
    else $error("control write did not land");
  a_mon_write: assert property (wr_en && hit(addr, `PRB_ADDR_MON_CFG)
      |=> mon_cfg == $past(wr_data))
    else $error("monitor config write did not land");
  a_en_write: assert property (wr_en && hit(addr, `PRB_ADDR_INT_EN)
      |=> en_r == $past(wr_data[3:0]))
    else $error("interrupt enable write did not land");
  a_ctrl_hold: assert property (!(wr_en && hit(addr, `PRB_ADDR_PLL_CTRL))
      |=> $stable(ctrl_r))
    else $error("control register changed without a write");
  a_ctrl_read: assert property (rd_en && hit(addr, `PRB_ADDR_PLL_CTRL)
      |=> rd_data == $past(ctrl_r))
    else $error("control read returned wrong data");
  a_mon_read: assert property (rd_en && hit(addr, `PRB_ADDR_MON_CFG)
      |=> rd_data == $past(thr_r))
    else $error("monitor config read returned wrong data");
  a_en_read: assert property (rd_en && hit(addr, `PRB_ADDR_INT_EN)
      |=> rd_data == {4'h0, $past(en_r)})
    else $error("interrupt enable read returned wrong data");
  a_stat_read: assert property (rd_en && hit(addr, `PRB_ADDR_INT_STAT)
      |=> rd_data == {4'h0, $past(int_st)})
    else $error("interrupt status read returned wrong data");
  a_clr_read: assert property (rd_en && hit(addr, `PRB_ADDR_INT_CLR)
      |=> rd_data == 8'h00)
    else $error("interrupt clear register does not read zero");
  a_set_wins: assert property (|ev_v
      |=> (int_st & $past(ev_v)) == $past(ev_v))
    else $error("event did not set its sticky bit");
  a_clr_works: assert property (wr_en && hit(addr, `PRB_ADDR_INT_CLR)
      |=> (int_st & $past(clr_v & ~ev_v)) == `PRB_RST_EVENTS)
    else $error("clear left a sticky bit set");
  a_irq_level: assert property (irq
      == |(int_st & $past(en_r)))
    else $error("interrupt line does not follow enabled status");
  a_lock_event: assert property ($changed(status_v[`PRB_BIT_LOCK])
      |-> ev_v[`PRB_EV_LOCK_CHG])
    else $error("lock change raised no event");
  a_cal_event: assert property ($rose(status_v[`PRB_BIT_CAL_DONE])
      |-> ev_v[`PRB_EV_CAL_DONE])
    else $error("calibration done raised no event");
  a_hold_event: assert property ($rose(status_v[`PRB_BIT_HOLD_ACT])
      |-> ev_v[`PRB_EV_HOLD_ENTER])
    else $error("holdover entry raised no event");
  a_ref_event: assert property ($changed(status_v[`PRB_BIT_SECOND_REFERENCE_INPUT_SEL])
      |-> ev_v[`PRB_EV_REF_SWITCH])
    else $error("reference switch raised no event");

  c_status_read: cover property (st_rd ##1 rd_data[0]);
  c_rb_disabled: cover property (rd_en && hit(addr, `PRB_ADDR_STATUS) && ctrl_r[`PRB_BIT_RB_DIS]);
  c_irq_raised:  cover property ($rose(irq));
  c_hold_enter:  cover property ($rose(status_v[5]));

endmodule : prb_status

// ---- prb_sync.sv ----
`timescale 1ns/1ps

// ********************************************************************
// Two-stage synchroniser for a bank of level inputs.
// ********************************************************************
module prb_sync #(
  parameter int WIDTH = 7
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Levels.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("prb_sync needs WIDTH of at least one");
  end

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule : prb_sync

// ---- tb.sv ----
`timescale 1ns/1ps
`include "prb_defines.svh"

module tb;

  // ********************************************************************
  // Signals.
  // ********************************************************************
  logic              clock;
  logic              rst_b;
  logic [9:0]        addr;
  prb_pkg::prb_byte_t wr_data;
  logic              wr_en;
  logic              rd_en;
  prb_pkg::prb_byte_t rd_data;
  logic [6:0]        pins;
  prb_pkg::prb_byte_t pll_ctrl;
  prb_pkg::prb_byte_t mon_cfg;
  logic              irq;
  int                error_cnt;
  int                checked;
  logic [31:0]       seed;
  logic [6:0]        pat;
  int                ev_pin [4] = '{0, 6, 5, 4};

  always #25 clock = ~clock;

  prb_status i_dut (
    .clock                       (clock),
    .rst_b                       (rst_b),
    .addr                        (addr),
    .wr_data                     (wr_data),
    .wr_en                       (wr_en),
    .rd_en                       (rd_en),
    .rd_data                     (rd_data),
    .vco_cal_done                (pins[6]),
    .holdover_state              (pins[5]),
    .second_reference_input_sel  (pins[4]),
    .vco_freq_high               (pins[3]),
    .second_reference_input_high (pins[2]),
    .first_reference_input_high  (pins[1]),
    .lock_detect                 (pins[0]),
    .pll_ctrl                    (pll_ctrl),
    .mon_cfg                     (mon_cfg),
    .irq                         (irq)
  );

  // ********************************************************************
  // Helpers.
  // ********************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  function automatic prb_pkg::prb_byte_t exp_status(input logic [6:0] p, input logic dis);
    return dis ? 8'h00 : {1'b0, p};
  endfunction : exp_status

  task automatic stop_test;
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input prb_pkg::prb_byte_t exp,
                     input prb_pkg::prb_byte_t got);
    checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [9:0] a, input prb_pkg::prb_byte_t d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [9:0] a, input prb_pkg::prb_byte_t exp, input string name);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(name, exp, rd_data);
  endtask : rd

  // The synchroniser needs two edges; three leave a settled value for the next read.
  task automatic set_pins(input logic [6:0] p);
    @(posedge clock);
    pins <= p;
    repeat (3) @(posedge clock);
  endtask : set_pins

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq !== lvl && n < 10)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    checked++;
    if (irq !== lvl)
    begin
      $display("Error irq expected %b seen %b", lvl, irq);
      error_cnt++;
      stop_test;
    end
  endtask : wait_irq

  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial
  begin
    clock     = 1'b0;
    rst_b     = 1'b0;
    addr      = 10'h000;
    wr_data   = 8'h00;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    pins      = 7'h00;
    error_cnt = 0;
    checked   = 0;
    seed      = 32'h1396;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    #1;
    chk("pll_ctrl", 8'h00, pll_ctrl);
    chk("mon_cfg", 8'h00, mon_cfg);
    chk("irq", 8'h00, {7'h00, irq});
    rd(`PRB_ADDR_PLL_CTRL, 8'h00, "pll_ctrl reg");
    rd(`PRB_ADDR_MON_CFG, 8'h00, "mon_cfg reg");
    rd(`PRB_ADDR_INT_EN, 8'h00, "int_en");
    rd(`PRB_ADDR_INT_STAT, 8'h00, "int_stat");
    rd(`PRB_ADDR_STATUS, 8'h00, "status reset");
    rd(10'h3FF, 8'h00, "unmapped");
    @(posedge clock);
    #1;
    chk("rd_data idle", 8'h00, rd_data);
    // Walking ones first, then random pin patterns.
    for (int i = 0; i < 31; i++)
    begin
      seed = xs(seed);
      pat  = (i < 7) ? (7'h01 << i) : seed[6:0];
      set_pins(pat);
      rd(`PRB_ADDR_STATUS, exp_status(pat, 1'b0), "status");
      wr(`PRB_ADDR_STATUS, seed[15:8]);
      rd(`PRB_ADDR_STATUS, exp_status(pat, 1'b0), "status after write");
    end
    set_pins(7'h00);
    wr(`PRB_ADDR_PLL_CTRL, 8'h07);
    chk("pll_ctrl", 8'h07, pll_ctrl);
    rd(`PRB_ADDR_STATUS, 8'h00, "holdover enabled only");
    set_pins(7'h20);
    rd(`PRB_ADDR_STATUS, 8'h20, "holdover active");
    wr(`PRB_ADDR_PLL_CTRL, 8'h10);
    rd(`PRB_ADDR_STATUS, exp_status(7'h20, 1'b1), "status disabled");
    rd(`PRB_ADDR_PLL_CTRL, 8'h10, "pll_ctrl reg");
    wr(`PRB_ADDR_PLL_CTRL, 8'h00);
    rd(`PRB_ADDR_STATUS, 8'h20, "status enabled");
    wr(`PRB_ADDR_MON_CFG, 8'h40);
    chk("mon_cfg", 8'h40, mon_cfg);
    rd(`PRB_ADDR_MON_CFG, 8'h40, "mon_cfg reg");
    // Each event kind raises the line on its own and is cleared by a one.
    wr(`PRB_ADDR_INT_EN, 8'h0F);
    rd(`PRB_ADDR_INT_EN, 8'h0F, "int_en");
    for (int e = 0; e < 4; e++)
    begin
      set_pins(7'h00);
      wr(`PRB_ADDR_INT_CLR, 8'h0F);
      wait_irq(1'b0);
      rd(`PRB_ADDR_INT_STAT, 8'h00, "int_stat cleared");
      @(posedge clock);
      pins <= 7'h01 << ev_pin[e];
      wait_irq(1'b1);
      rd(`PRB_ADDR_INT_STAT, 8'h01 << e, "int_stat event");
      rd(`PRB_ADDR_INT_CLR, 8'h00, "int_clr read");
      wr(`PRB_ADDR_INT_CLR, 8'h01 << e);
      chk("irq after clear", 8'h00, {7'h00, irq});
    end
    // A masked event is recorded but keeps the line low.
    set_pins(7'h00);
    wr(`PRB_ADDR_INT_EN, 8'h00);
    wr(`PRB_ADDR_INT_CLR, 8'h0F);
    set_pins(7'h01);
    repeat (3) @(posedge clock);
    #1;
    chk("irq masked", 8'h00, {7'h00, irq});
    rd(`PRB_ADDR_INT_STAT, 8'h01, "int_stat masked");
    wr(`PRB_ADDR_INT_EN, 8'h01);
    wait_irq(1'b1);
    wr(`PRB_ADDR_INT_CLR, 8'h01);
    wait_irq(1'b0);
    stop_test;
  end

endmodule : tb
